// file: core/rcf_pkg.sv
// Shared constants, types and decoders of the reset command and flags block.
// Assumes a single 20 MHz core clock and an Avalon-MM slave with byte addresses.
package rcf_pkg;

    localparam int RCF_ADDR_W = 18;
    localparam int RCF_BUS_W = 32;
    localparam int RCF_REG_W = 8;
    localparam int RCF_BE_W = RCF_BUS_W / 8;
    localparam int RCF_IDX_W = 16;

    // Register indices; the byte address is four times the index
    localparam logic [RCF_IDX_W-1:0] RCF_IDX_CMD = 16'ha017;
    localparam logic [RCF_IDX_W-1:0] RCF_IDX_STAT = 16'ha018;
    localparam logic [RCF_IDX_W-1:0] RCF_IDX_MASK = 16'ha019;

    // Write layout of reset_command
    localparam int RCF_BIT_CKM_EN = 7;
    localparam int RCF_BIT_ECC_EN = 6;
    localparam int RCF_BIT_FLAG_CLEAR = 4;
    localparam int RCF_KEY_W = 4;

    // Flag and event layout, shared by read data, status and mask
    localparam int RCF_EV_W = 4;
    localparam int RCF_F_CKM = 3;
    localparam int RCF_F_ECC = 2;
    localparam int RCF_F_WDT = 1;
    localparam int RCF_F_CMD = 0;

    localparam logic [RCF_KEY_W-1:0] RCF_KEY_FIRST = 4'h5;
    localparam logic [RCF_KEY_W-1:0] RCF_KEY_SECOND = 4'ha;
    localparam logic [RCF_REG_W-1:0] RCF_CMD_RESET = 8'h00;
    localparam logic [RCF_EV_W-1:0] RCF_EV_NONE = 4'h0;

    // Slow oscillator periods without a system clock beat before a fault
    localparam int RCF_MISS_W = 3;
    localparam logic [RCF_MISS_W-1:0] RCF_MISS_LIMIT = 3'h4;
    localparam int RCF_SYNC_N = 3;

    typedef enum logic [1:0]
    {
        RCF_KEY_IDLE = 2'b01,
        RCF_KEY_ARMED = 2'b10
    } rcf_key_t;

    typedef struct packed
    {
        logic read;
        logic write;
        logic [RCF_ADDR_W-1:0] address;
        logic [RCF_BE_W-1:0] byteenable;
        logic [RCF_BUS_W-1:0] writedata;
    } rcf_av_req_t;

    typedef struct packed
    {
        logic [RCF_EV_W-1:0] flags;
        logic ckm_en;
        logic ecc_en;
        rcf_key_t key;
        logic [RCF_EV_W-1:0] irq_stat;
        logic [RCF_EV_W-1:0] irq_mask;
        logic ack;
        logic [RCF_REG_W-1:0] rdata;
        logic soft_req;
        logic hw_req;
    } rcf_state_t;

    typedef struct packed
    {
        logic [RCF_SYNC_N-1:0] osc_sync;
        logic [RCF_SYNC_N-1:0] beat_sync;
        logic osc_lvl;
        logic beat_lvl;
        logic [RCF_MISS_W-1:0] miss;
        logic fired;
        logic fault;
    } rcf_mon_state_t;

    function automatic logic rcf_hit(input logic [RCF_ADDR_W-1:0] addr,
                                     input logic [RCF_IDX_W-1:0] idx);
        rcf_hit = (addr == {idx, 2'b00});
    endfunction : rcf_hit

endpackage : rcf_pkg

// file: core/rcf_clk_mon.sv
// Clock monitor: counts slow oscillator periods with no system clock beat.
// Assumes slow_osc and sys_beat arrive asynchronously from pins or other domains.
module rcf_clk_mon
    import rcf_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic slow_osc,
    input wire logic sys_beat,
    input wire logic normal_mode,
    output logic clock_fault
);

    rcf_mon_state_t st_reg;
    rcf_mon_state_t st_next;
    logic osc_rise;
    logic beat_change;

    always_comb
    begin
        st_next = st_reg;
        st_next.osc_sync = {st_reg.osc_sync[RCF_SYNC_N-2:0], slow_osc};
        st_next.beat_sync = {st_reg.beat_sync[RCF_SYNC_N-2:0], sys_beat};
        // A level counts once the second and third stages agree
        if (st_reg.osc_sync[1] == st_reg.osc_sync[2])
        begin
            st_next.osc_lvl = st_reg.osc_sync[2];
        end
        if (st_reg.beat_sync[1] == st_reg.beat_sync[2])
        begin
            st_next.beat_lvl = st_reg.beat_sync[2];
        end
        osc_rise = st_next.osc_lvl && !st_reg.osc_lvl;
        beat_change = st_next.beat_lvl != st_reg.beat_lvl;
        st_next.fault = 1'b0;
        if (beat_change || !normal_mode)
        begin
            st_next.miss = '0;
            st_next.fired = 1'b0;
        end
        else if (osc_rise && !st_reg.fired)
        begin
            st_next.miss = st_reg.miss + 1'b1;
            if (st_next.miss == RCF_MISS_LIMIT)
            begin
                st_next.fault = 1'b1;
                st_next.fired = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign clock_fault = st_reg.fault;

endmodule : rcf_clk_mon

// file: core/rcf_reset_cmd.sv
// Reset command register, reset cause flags and their interrupt.
// Assumes an Avalon-MM master on core_clk and rst driven by power-on reset.
//
// Operation
// - Key 0101 then 1010 starts software reset
// - Wrong key returns tracker idle; key write-only
// - Clock-fault enable resets; cleared after any reset
// - ECC enable makes fetch ECC error reset
// - Clock-fault flag set by hardware, POR-only clear; here the flag-clear bit clears it too
// - Flag-clear bit clears four flags, self-clears
// - Bits 7..4 read zero; flags readable
// - Writes write-protected; register resets to zero
// - Four slow periods without clock: fault
// - Soft resets keep some registers; hard resets all
//
// The Avalon-MM slave port was left to the implementer.
module rcf_reset_cmd
    import rcf_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire rcf_av_req_t avs_req,
    output logic avs_waitrequest,
    output logic [RCF_BUS_W-1:0] avs_readdata,
    input wire logic write_protect,
    input wire logic slow_osc,
    input wire logic sys_beat,
    input wire logic normal_mode,
    input wire logic ecc_fetch_err,
    input wire logic wdt_reset,
    input wire logic hw_reset,
    output logic soft_reset_req,
    output logic hw_reset_req,
    output logic irq
);

    rcf_state_t st_reg;
    rcf_state_t st_next;
    logic clock_fault;
    logic req;
    logic wr_go;
    logic wr_cmd;
    logic wr_stat;
    logic wr_mask;
    logic [RCF_KEY_W-1:0] key_in;
    logic soft_cmd;
    logic ckm_rst;
    logic ecc_rst;
    logic any_reset;
    logic hard_reset;
    logic [RCF_EV_W-1:0] flag_set;
    logic [RCF_EV_W-1:0] events;
    logic [RCF_EV_W-1:0] stat_clr;

    rcf_clk_mon u_clk_mon
    (
        .core_clk(core_clk),
        .rst(rst),
        .slow_osc(slow_osc),
        .sys_beat(sys_beat),
        .normal_mode(normal_mode),
        .clock_fault(clock_fault)
    );

    function automatic logic [RCF_REG_W-1:0] rd_mux(input rcf_state_t s,
                                                   input logic [RCF_ADDR_W-1:0] a);
        rd_mux = '0;
        if (rcf_hit(a, RCF_IDX_CMD))
        begin
            rd_mux = {{(RCF_REG_W-RCF_EV_W){1'b0}}, s.flags};
        end
        else if (rcf_hit(a, RCF_IDX_STAT))
        begin
            rd_mux = {{(RCF_REG_W-RCF_EV_W){1'b0}}, s.irq_stat};
        end
        else if (rcf_hit(a, RCF_IDX_MASK))
        begin
            rd_mux = {{(RCF_REG_W-RCF_EV_W){1'b0}}, s.irq_mask};
        end
    endfunction : rd_mux

    always_comb
    begin
        st_next = st_reg;
        st_next.soft_req = 1'b0;
        st_next.hw_req = 1'b0;
        req = avs_req.read || avs_req.write;
        // One wait state: the request is taken at the second edge
        st_next.ack = req && !st_reg.ack;
        wr_go = avs_req.write && st_reg.ack && avs_req.byteenable[0];
        wr_cmd = wr_go && rcf_hit(avs_req.address, RCF_IDX_CMD) && !write_protect;
        wr_stat = wr_go && rcf_hit(avs_req.address, RCF_IDX_STAT);
        wr_mask = wr_go && rcf_hit(avs_req.address, RCF_IDX_MASK);
        key_in = avs_req.writedata[RCF_KEY_W-1:0];
        if (st_next.ack)
        begin
            st_next.rdata = rd_mux(st_reg, avs_req.address);
        end

        soft_cmd = wr_cmd && (st_reg.key == RCF_KEY_ARMED) && (key_in == RCF_KEY_SECOND);
        ckm_rst = clock_fault && st_reg.ckm_en;
        ecc_rst = ecc_fetch_err && st_reg.ecc_en;
        any_reset = soft_cmd || ckm_rst || ecc_rst || wdt_reset || hw_reset;
        hard_reset = ckm_rst || hw_reset;

        if (wr_cmd)
        begin
            st_next.ckm_en = avs_req.writedata[RCF_BIT_CKM_EN];
            st_next.ecc_en = avs_req.writedata[RCF_BIT_ECC_EN];
            // Every write presents a key value, so any other value breaks the sequence
            if (st_reg.key == RCF_KEY_IDLE && key_in == RCF_KEY_FIRST)
            begin
                st_next.key = RCF_KEY_ARMED;
            end
            else
            begin
                st_next.key = RCF_KEY_IDLE;
            end
            if (avs_req.writedata[RCF_BIT_FLAG_CLEAR])
            begin
                st_next.flags = RCF_EV_NONE;
            end
        end

        // Any reset drops the clock-fault enable and the key tracker
        if (any_reset)
        begin
            st_next.ckm_en = 1'b0;
            st_next.key = RCF_KEY_IDLE;
        end
        // Only hardware resets restore the ECC enable too
        if (hard_reset)
        begin
            st_next.ecc_en = 1'b0;
        end

        // Setting wins over a flag clear in the same cycle
        flag_set = RCF_EV_NONE;
        flag_set[RCF_F_CKM] = ckm_rst;
        flag_set[RCF_F_ECC] = ecc_rst;
        flag_set[RCF_F_WDT] = wdt_reset;
        flag_set[RCF_F_CMD] = soft_cmd;
        st_next.flags = st_next.flags | flag_set;

        st_next.soft_req = soft_cmd || ecc_rst;
        st_next.hw_req = ckm_rst;

        events = RCF_EV_NONE;
        events[RCF_F_CKM] = clock_fault;
        events[RCF_F_ECC] = ecc_fetch_err;
        events[RCF_F_WDT] = wdt_reset;
        events[RCF_F_CMD] = soft_cmd;
        stat_clr = wr_stat ? avs_req.writedata[RCF_EV_W-1:0] : RCF_EV_NONE;
        st_next.irq_stat = (st_reg.irq_stat & ~stat_clr) | events;
        if (wr_mask)
        begin
            st_next.irq_mask = avs_req.writedata[RCF_EV_W-1:0];
        end
    end

    // Power-on reset: every field but the key tracker to zero, flags included; tracker to idle
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            st_reg <= '0;
            st_reg.key <= RCF_KEY_IDLE;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign avs_waitrequest = (avs_req.read || avs_req.write) && !st_reg.ack;
    assign avs_readdata = {{(RCF_BUS_W-RCF_REG_W){1'b0}}, st_reg.rdata};
    assign soft_reset_req = st_reg.soft_req;
    assign hw_reset_req = st_reg.hw_req;
    assign irq = |(st_reg.irq_stat & st_reg.irq_mask);

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    // Assertion helpers
    logic cmd_wr_a_h;
    logic stat_wr_a_h;
    logic mask_wr_a_h;
    logic clr_wr_a_h;
    logic [RCF_KEY_W-1:0] key_a_h;
    logic [RCF_EV_W-1:0] wdata_lo_a_h;
    assign cmd_wr_a_h = avs_req.write && st_reg.ack && avs_req.byteenable[0]
        && rcf_hit(avs_req.address, RCF_IDX_CMD) && !write_protect;
    assign stat_wr_a_h = avs_req.write && st_reg.ack && avs_req.byteenable[0]
        && rcf_hit(avs_req.address, RCF_IDX_STAT);
    assign mask_wr_a_h = avs_req.write && st_reg.ack && avs_req.byteenable[0]
        && rcf_hit(avs_req.address, RCF_IDX_MASK);
    assign clr_wr_a_h = cmd_wr_a_h && avs_req.writedata[RCF_BIT_FLAG_CLEAR];
    assign key_a_h = avs_req.writedata[RCF_KEY_W-1:0];
    assign wdata_lo_a_h = avs_req.writedata[RCF_EV_W-1:0];

    sequence first_key_s;
        cmd_wr_a_h && key_a_h == RCF_KEY_FIRST && st_reg.key == RCF_KEY_IDLE
            && !any_reset;
    endsequence

    // Second key only counts while the tracker is still armed
    sequence second_key_s;
        cmd_wr_a_h && key_a_h == RCF_KEY_SECOND && st_reg.key == RCF_KEY_ARMED;
    endsequence

    sequence bad_key_s;
        cmd_wr_a_h && st_reg.key == RCF_KEY_ARMED && key_a_h != RCF_KEY_SECOND;
    endsequence

    // Cycle in which waitrequest drops under a read
    sequence rd_answer_s;
        avs_req.read && !avs_waitrequest;
    endsequence

    // Four cycles with no flag clear, counted from the cycle a flag rises
    sequence clr_quiet_s;
        !clr_wr_a_h [*4];
    endsequence

    // Key sequence
    key_arm_a: assert property (first_key_s |=> st_reg.key == RCF_KEY_ARMED)
        else $error("first key did not arm the tracker");

    key_reset_a: assert property (first_key_s ##[1:9] second_key_s
        |=> soft_reset_req && st_reg.flags[RCF_F_CMD] ##1 !soft_reset_req)
        else $error("key sequence did not give one soft reset pulse");

    key_break_a: assert property (bad_key_s |=> st_reg.key == RCF_KEY_IDLE
        && !soft_reset_req)
        else $error("wrong key did not return tracker to idle");

    // Reset requests and enables
    ckm_clear_a: assert property (any_reset |=> !st_reg.ckm_en)
        else $error("clock fault enable survived a reset");

    ckm_fault_a: assert property (clock_fault && st_reg.ckm_en
        |=> hw_reset_req && st_reg.flags[RCF_F_CKM])
        else $error("enabled clock fault gave no reset or flag");

    ckm_off_a: assert property (clock_fault && !st_reg.ckm_en
        |=> !hw_reset_req)
        else $error("disabled clock fault caused a reset");

    hw_cause_a: assert property (!ckm_rst |=> !hw_reset_req)
        else $error("hardware reset request without a clock fault");

    hw_pulse_a: assert property (hw_reset_req |=> !hw_reset_req)
        else $error("hardware reset request longer than one cycle");

    ecc_fault_a: assert property (ecc_fetch_err && st_reg.ecc_en
        |=> soft_reset_req && st_reg.flags[RCF_F_ECC])
        else $error("enabled ECC error gave no reset or flag");

    ecc_off_a: assert property (ecc_fetch_err && !st_reg.ecc_en && !soft_cmd
        |=> !soft_reset_req && !hw_reset_req)
        else $error("disabled ECC error caused a reset");

    soft_cause_a: assert property (!soft_cmd && !ecc_rst
        |=> !soft_reset_req)
        else $error("soft reset request without a cause");

    hard_ecc_a: assert property (hw_reset |=> !st_reg.ecc_en)
        else $error("hardware reset kept the ECC enable");

    soft_keep_a: assert property (wdt_reset && !hw_reset && !ckm_rst && !wr_cmd
        |=> $stable(st_reg.ecc_en))
        else $error("soft reset changed the ECC enable");

    // Flags
    flag_clear_a: assert property (clr_wr_a_h && !any_reset
        |=> st_reg.flags == RCF_EV_NONE)
        else $error("flag clear left a flag set");

    flag_hold_a: assert property ($rose(st_reg.flags[RCF_F_CKM]) ##0 clr_quiet_s
        |-> st_reg.flags[RCF_F_CKM])
        else $error("clock fault flag dropped without a clear");

    ecc_hold_a: assert property ($rose(st_reg.flags[RCF_F_ECC]) ##0 clr_quiet_s
        |-> st_reg.flags[RCF_F_ECC])
        else $error("ECC flag dropped without a clear");

    wdt_flag_a: assert property (wdt_reset |=> st_reg.flags[RCF_F_WDT])
        else $error("watchdog reset did not set its flag");

    // Register reads
    read_high_a: assert property (!avs_waitrequest && avs_req.read
        |-> avs_readdata[RCF_REG_W-1:RCF_EV_W] == '0)
        else $error("upper read bits not zero");

    rd_upper_a: assert property (avs_readdata[RCF_BUS_W-1:RCF_REG_W] == '0)
        else $error("read data above the register width not zero");

    rd_cmd_a: assert property (rd_answer_s ##0 rcf_hit(avs_req.address, RCF_IDX_CMD)
        |-> avs_readdata[RCF_EV_W-1:0] == $past(st_reg.flags))
        else $error("reset command read did not show the flags");

    rd_stat_a: assert property (rd_answer_s ##0 rcf_hit(avs_req.address, RCF_IDX_STAT)
        |-> avs_readdata[RCF_EV_W-1:0] == $past(st_reg.irq_stat))
        else $error("status read did not show the status bits");

    rd_mask_a: assert property (rd_answer_s ##0 rcf_hit(avs_req.address, RCF_IDX_MASK)
        |-> avs_readdata[RCF_EV_W-1:0] == $past(st_reg.irq_mask))
        else $error("mask read did not show the mask bits");

    // Interrupt status and mask
    mask_write_a: assert property (mask_wr_a_h
        |=> st_reg.irq_mask == $past(wdata_lo_a_h))
        else $error("mask write did not land");

    irq_mask_a: assert property (st_reg.irq_mask == RCF_EV_NONE |-> !irq)
        else $error("interrupt raised with every source masked");

    for (genvar i = 0; i < RCF_EV_W; i++)
    begin : g_stat_chk
        stat_set_a: assert property (events[i] |=> st_reg.irq_stat[i])
            else $error("event did not set its status bit");
        stat_clear_a: assert property (stat_wr_a_h && wdata_lo_a_h[i] && !events[i]
            |=> !st_reg.irq_stat[i])
            else $error("written one did not clear a status bit");
    end

    // Write protection and bus timing
    protect_a: assert property (avs_req.write && st_reg.ack && write_protect
        && !any_reset |=> $stable(st_reg.ckm_en) && $stable(st_reg.ecc_en))
        else $error("protected write changed the enables");

    key_protect_a: assert property (avs_req.write && st_reg.ack && write_protect
        && !any_reset |=> $stable(st_reg.key))
        else $error("protected write moved the key tracker");

    read_quiet_a: assert property (avs_req.read && !avs_req.write && !any_reset
        |=> $stable(st_reg.key) && $stable(st_reg.ckm_en) && $stable(st_reg.ecc_en))
        else $error("read changed the command state");

    wait_one_a: assert property ($rose(avs_req.read || avs_req.write)
        |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("slave did not answer after one wait state");

    idle_wait_a: assert property (!avs_req.read && !avs_req.write |-> !avs_waitrequest)
        else $error("waitrequest high with no request");

endmodule : rcf_reset_cmd

// file: dv/testbench.sv
// Self-checking bench of the reset command register, its flags and its interrupt.
// Assumes the block is alone on its Avalon-MM bus and owns all event inputs.
module testbench
    import rcf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    rcf_av_req_t req = '0;
    logic avs_waitrequest;
    logic [RCF_BUS_W-1:0] avs_readdata;
    logic write_protect = 1'b0;
    logic slow_osc = 1'b0;
    logic sys_beat = 1'b0;
    logic normal_mode = 1'b0;
    logic [2:0] ev = 3'h0;
    logic soft_reset_req;
    logic hw_reset_req;
    logic irq;
    int err_count = 0;
    int num_checks = 0;
    int soft_cnt = 0;
    int hw_cnt = 0;
    int cycles = 0;
    int n_exp;
    logic [31:0] seed = 32'ha57100cc;
    logic [31:0] q;

    always #25 core_clk = ~core_clk;

    rcf_reset_cmd dut (
        .core_clk(core_clk),
        .rst(rst),
        .avs_req(req),
        .avs_waitrequest(avs_waitrequest),
        .avs_readdata(avs_readdata),
        .write_protect(write_protect),
        .slow_osc(slow_osc),
        .sys_beat(sys_beat),
        .normal_mode(normal_mode),
        .ecc_fetch_err(ev[0]),
        .wdt_reset(ev[1]),
        .hw_reset(ev[2]),
        .soft_reset_req(soft_reset_req),
        .hw_reset_req(hw_reset_req),
        .irq(irq)
    );

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task automatic give_verdict();
        if (err_count == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : give_verdict

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : check

    // Reset request pulses are counted mid-cycle, away from the launching edge
    always @(negedge core_clk)
    begin
        if (rst === 1'b0 && soft_reset_req === 1'b1)
            soft_cnt++;
        if (rst === 1'b0 && hw_reset_req === 1'b1)
            hw_cnt++;
    end

    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            err_count++;
            give_verdict();
        end
    end

    // One Avalon transfer; held until the rising edge that sees waitrequest low
    task automatic bus(input logic wr, input logic [15:0] idx, input logic [7:0] d);
        @(posedge core_clk);
        req.read <= ~wr;
        req.write <= wr;
        req.address <= {idx, 2'b00};
        req.byteenable <= 4'h1;
        req.writedata <= {24'h0, d};
        @(posedge core_clk);
        while (avs_waitrequest !== 1'b0)
        begin
            @(posedge core_clk);
        end
        q = avs_readdata;
        req.read <= 1'b0;
        req.write <= 1'b0;
    endtask : bus

    task automatic wr(input logic [15:0] idx, input logic [7:0] d);
        bus(1'b1, idx, d);
    endtask : wr

    task automatic rd_chk(input logic [15:0] idx, input logic [7:0] e);
        bus(1'b0, idx, 8'h00);
        check(q, {24'h0, e});
    endtask : rd_chk

    task automatic key(input logic [3:0] k);
        wr(RCF_IDX_CMD, {4'h0, k});
    endtask : key

    task automatic irq_chk(input logic e);
        @(negedge core_clk);
        check(irq, e);
    endtask : irq_chk

    task automatic pulse(input logic [2:0] v);
        @(posedge core_clk);
        ev <= v;
        @(posedge core_clk);
        ev <= 3'h0;
        repeat (3) @(posedge core_clk);
    endtask : pulse

    // Slow oscillator edges while the system clock beat stands still
    task automatic osc(input int n);
        repeat (n)
        begin
            repeat (8) @(posedge core_clk);
            slow_osc <= 1'b1;
            repeat (8) @(posedge core_clk);
            slow_osc <= 1'b0;
        end
        repeat (10) @(posedge core_clk);
    endtask : osc

    // Random keys against a model of the two-step key tracker
    task automatic rand_keys(output int exp);
        logic armed;
        logic [3:0] k;
        armed = 1'b0;
        exp = soft_cnt;
        repeat (24)
        begin
            seed = lfsr(seed);
            k = seed[4] ? (seed[5] ? RCF_KEY_FIRST : RCF_KEY_SECOND) : seed[3:0];
            key(k);
            if (k == RCF_KEY_FIRST && !armed)
                armed = 1'b1;
            else
            begin
                if (k == RCF_KEY_SECOND && armed)
                    exp++;
                armed = 1'b0;
            end
        end
        repeat (3) @(posedge core_clk);
    endtask : rand_keys

    initial
    begin
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        rd_chk(RCF_IDX_CMD, 8'h00);
        rd_chk(RCF_IDX_STAT, 8'h00);
        rd_chk(16'ha01a, 8'h00);
        irq_chk(1'b0);
        wr(RCF_IDX_MASK, 8'h0f);
        key(4'h5);
        key(4'ha);
        repeat (2) @(posedge core_clk);
        check(soft_cnt, 1);
        rd_chk(RCF_IDX_CMD, 8'h01);
        rd_chk(RCF_IDX_STAT, 8'h01);
        irq_chk(1'b1);
        key(4'h5);
        key(4'h3);
        key(4'ha);
        key(4'h5);
        key(4'h5);
        key(4'ha);
        write_protect <= 1'b1;
        key(4'h5);
        key(4'ha);
        wr(RCF_IDX_CMD, 8'h10);
        write_protect <= 1'b0;
        repeat (2) @(posedge core_clk);
        check(soft_cnt, 1);
        rd_chk(RCF_IDX_CMD, 8'h01);
        wr(RCF_IDX_STAT, 8'h0f);
        irq_chk(1'b0);
        pulse(3'b001);
        check(soft_cnt, 1);
        rd_chk(RCF_IDX_STAT, 8'h04);
        wr(RCF_IDX_CMD, 8'h40);
        pulse(3'b001);
        check(soft_cnt, 2);
        rd_chk(RCF_IDX_CMD, 8'h05);
        pulse(3'b010);
        wr(RCF_IDX_CMD, 8'hc0);
        rd_chk(RCF_IDX_CMD, 8'h07);
        wr(RCF_IDX_CMD, 8'h10);
        rd_chk(RCF_IDX_CMD, 8'h00);
        pulse(3'b010);
        wr(RCF_IDX_CMD, 8'h00);
        rd_chk(RCF_IDX_CMD, 8'h02);
        wr(RCF_IDX_CMD, 8'h10);
        wr(RCF_IDX_STAT, 8'h0f);
        wr(RCF_IDX_MASK, 8'h00);
        wr(RCF_IDX_CMD, 8'h80);
        normal_mode <= 1'b1;
        osc(6);
        check(hw_cnt, 1);
        rd_chk(RCF_IDX_CMD, 8'h08);
        pulse(3'b100);
        rd_chk(RCF_IDX_CMD, 8'h08);
        sys_beat <= 1'b1;
        wr(RCF_IDX_CMD, 8'h80);
        pulse(3'b010);
        osc(6);
        check(hw_cnt, 1);
        rd_chk(RCF_IDX_STAT, 8'h0a);
        normal_mode <= 1'b0;
        irq_chk(1'b0);
        wr(RCF_IDX_MASK, 8'h02);
        irq_chk(1'b1);
        wr(RCF_IDX_STAT, 8'h02);
        irq_chk(1'b0);
        wr(RCF_IDX_CMD, 8'h10);
        rand_keys(n_exp);
        check(soft_cnt, n_exp);
        give_verdict();
    end
endmodule : testbench
